// file: verilog/tlfc_torque_limit.sv
/*
 * Torque limit selection, limited flag, flux forcing run gate and
 * torque monitor routing. Assumes terminal pins are asynchronous,
 * all other inputs come from logic on mclk.
 */
`timescale 1ns/100ps
`default_nettype none

module tlfc_torque_limit #(
	parameter int N_IN  = 8, // Intelligent input terminals
	parameter int N_OUT = 5  // Intelligent output terminals
) (
	input  wire logic                mclk,
	input  wire logic                rst,
	input  wire logic [4:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [7:0]          reg_rdata,
	input  wire logic [N_IN-1:0]     in_term,
	output logic      [N_OUT-1:0]    out_term,
	input  wire logic                run_cmd,
	input  wire logic                motor_reverse,
	input  wire logic                motor_regen,
	input  wire logic [8:0]          torque_demand,
	input  wire logic signed [15:0]  torque_est,
	input  wire logic [9:0]          auxiliary_analog_input,
	input  wire logic                option_present,
	input  wire logic [7:0]          option_limit,
	output logic      [7:0]          torque_limit_value,
	output logic                     torque_limit_on,
	output logic                     torque_limited_flag,
	output logic                     run_enable,
	output logic                     coast_request,
	output logic                     restart_pulse,
	output logic      [7:0]          restart_after_coast_mode,
	output logic                     flux_forcing_active,
	output logic                     torque_valid,
	output logic signed [15:0]       torque_display_code,
	output logic      [15:0]         pulse_monitor_value,
	output logic signed [15:0]       voltage_monitor_value,
	output logic      [15:0]         current_monitor_value,
	output logic      [7:0]          pole_count_active
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0]              meth1;  // Control method set 1
		logic [7:0]              meth2;  // Control method set 2
		logic                    mset;   // Second set in use
		logic [7:0]              lmode;  // Limit mode select
		logic [3:0][7:0]         lim;    // Stored limits 1..4
		logic [7:0]              pmon;   // Pulse monitor select
		logic [7:0]              vmon;   // Voltage monitor select
		logic [7:0]              cmon;   // Current monitor select
		logic [7:0]              rmode;  // Restart after coast
		logic [7:0]              pole1;  // Poles set 1
		logic [7:0]              pole2;  // Poles set 2
		logic [N_IN-1:0][7:0]    ifn;    // Input functions
		logic [N_OUT-1:0][7:0]   ofn;    // Output functions
		logic [N_IN-1:0]         s1;     // Pin sync stage 1
		logic [N_IN-1:0]         s2;     // Pin sync stage 2
		logic [N_IN-1:0]         s3;     // Pin sync stage 3
		logic [N_IN-1:0]         filt;   // Agreed pin levels
		tlfc_pkg::tlfc_run_e     run;    // Run gate state
		logic [7:0]              lval;   // Limit in force
		logic                    lon;    // A finite limit applies
		logic                    lflag;  // Limiting now
		logic                    restart;// Restart pulse
		logic                    tqv;    // Torque valid
		logic signed [15:0]      disp;   // Torque display
		logic [15:0]             pmv;    // Pulse monitor
		logic signed [15:0]      vmv;    // Voltage monitor
		logic [15:0]             cmv;    // Current monitor
		logic [N_OUT-1:0]        oterm;  // Output terminals
		logic [7:0]              rdata;  // Read data
	} tlfc_state_s;

	tlfc_state_s q;       // Registered state
	tlfc_state_s d;       // Next state

	// ****************************************
	// Per-terminal decode
	// ****************************************
	logic [N_IN-1:0]  m_len;    // Terminals holding limit enable
	logic [N_IN-1:0]  m_sw1;    // Terminals holding switch one
	logic [N_IN-1:0]  m_sw2;    // Terminals holding switch two
	logic [N_IN-1:0]  m_frc;    // Terminals holding forcing
	logic [N_IN-1:0]  filt_nx;  // Next agreed pin levels
	logic [N_OUT-1:0] m_tql;    // Terminals given limited function

	genvar gi;
	generate
		for (gi = 0; gi < N_IN; gi++) begin : g_in
			// Pin change counts once stages two and three agree
			assign filt_nx[gi] = (q.s2[gi] == q.s3[gi]) ? q.s2[gi] : q.filt[gi];
			assign m_len[gi]   = (q.ifn[gi] == tlfc_pkg::F_LEN);
			assign m_sw1[gi]   = (q.ifn[gi] == tlfc_pkg::F_SW1);
			assign m_sw2[gi]   = (q.ifn[gi] == tlfc_pkg::F_SW2);
			assign m_frc[gi]   = (q.ifn[gi] == tlfc_pkg::F_FORCE);
		end
		for (gi = 0; gi < N_OUT; gi++) begin : g_out
			// Terminal shows limiting only when given that function
			assign m_tql[gi] = (q.ofn[gi] == tlfc_pkg::O_TQLIM);
		end
	endgenerate

	// ****************************************
	// Decision logic
	// ****************************************
	logic [7:0]         meth;     // Method of active set
	logic               vec;      // Vector method in use
	logic               len_asg;  // Enable function assigned
	logic               len_on;   // Enable input on
	logic               sw1;      // Switch one on
	logic               sw2;      // Switch two on
	logic               frc_asg;  // Forcing assigned
	logic               frc_on;   // Forcing input on
	logic               run_ok;   // Runs may be accepted
	logic [7:0]         lsel;     // Limit picked by mode
	logic [17:0]        ana_prod; // Analog scaling product
	logic signed [15:0] tq;       // Torque gated by validity
	logic [15:0]        tq_abs;   // Torque magnitude
	logic               lim_ok;   // Write value is legal limit
	logic               pole_ok;  // Write value is legal pole count

	assign meth    = q.mset ? q.meth2 : q.meth1;
	// Limiting and forcing only under the vector methods
	assign vec     = (meth == tlfc_pkg::M_SLV) || (meth == tlfc_pkg::M_SLV0)
	              || (meth == tlfc_pkg::M_SENSOR);
	assign len_asg = |m_len;
	assign len_on  = |(m_len & q.filt);
	assign sw1     = |(m_sw1 & q.filt);
	assign sw2     = |(m_sw2 & q.filt);
	assign frc_asg = vec & (|m_frc);
	assign frc_on  = |(m_frc & q.filt);
	// Without a forcing terminal runs pass freely
	assign run_ok  = !frc_asg || frc_on;
	// 0..10 V as full code gives 0..150 % of rated torque, up to maximum torque
	assign ana_prod = 18'(auxiliary_analog_input) * 18'(tlfc_pkg::LIM_MAX);
	assign tq      = vec ? torque_est : 16'sh0000;
	assign tq_abs  = tq[15] ? 16'(-tq) : 16'(tq);
	assign lim_ok  = (reg_wdata <= tlfc_pkg::LIM_MAX) || (reg_wdata == tlfc_pkg::LIM_NO);
	assign pole_ok = (reg_wdata == 8'h02) || (reg_wdata == 8'h04) || (reg_wdata == 8'h06)
	              || (reg_wdata == 8'h08) || (reg_wdata == 8'h0a);

	// Next state of the whole block
	always_comb begin
		d = q;
		// Pin synchronisers
		d.s1   = in_term;
		d.s2   = q.s1;
		d.s3   = q.s2;
		d.filt = filt_nx;

		// Register writes, illegal values leave the old setting
		if (reg_wr) begin
			unique case (reg_addr)
				tlfc_pkg::A_METH1: if (reg_wdata <= tlfc_pkg::M_SENSOR) d.meth1 = reg_wdata;
				// Sensor vector is not offered for set two
				tlfc_pkg::A_METH2: if (reg_wdata < tlfc_pkg::M_SENSOR) d.meth2 = reg_wdata;
				tlfc_pkg::A_MSET:  d.mset = reg_wdata[0];
				tlfc_pkg::A_LMODE: begin
					// Option modes accepted only with the board fitted
					if (reg_wdata <= tlfc_pkg::L_ANA
					    || (reg_wdata <= tlfc_pkg::L_OPT2 && option_present)) begin
						d.lmode = reg_wdata;
					end
				end
				tlfc_pkg::A_PMON:  d.pmon = reg_wdata;
				tlfc_pkg::A_VMON:  d.vmon = reg_wdata;
				tlfc_pkg::A_CMON:  d.cmon = reg_wdata;
				tlfc_pkg::A_RMODE: d.rmode = reg_wdata;
				tlfc_pkg::A_POLE1: if (pole_ok) d.pole1 = reg_wdata;
				tlfc_pkg::A_POLE2: if (pole_ok) d.pole2 = reg_wdata;
				default: begin
					// Limit tables and terminal functions by range
					if (reg_addr[4:2] == 3'b001 && lim_ok) begin
						d.lim[reg_addr[1:0]] = reg_wdata;
					end else if (reg_addr[4:3] == 2'b10) begin
						d.ifn[reg_addr[2:0]] = reg_wdata;
					end else if (reg_addr >= tlfc_pkg::A_OFN0
					             && reg_addr <= tlfc_pkg::A_OFN4) begin
						d.ofn[3'(reg_addr - tlfc_pkg::A_OFN0)] = reg_wdata;
					end
				end
			endcase
		end

		// Limit picked by the mode
		unique case (q.lmode)
			tlfc_pkg::L_QUAD: begin
				// Fwd power 1, rev regen 2, rev power 3, fwd regen 4
				unique case ({motor_reverse, motor_regen})
					2'b00:   lsel = q.lim[0];
					2'b11:   lsel = q.lim[1];
					2'b10:   lsel = q.lim[2];
					default: lsel = q.lim[3];
				endcase
			end
			tlfc_pkg::L_TERM: begin
				// Switch two alone picks limit four, both pick three
				unique case ({sw2, sw1})
					2'b00:   lsel = q.lim[0];
					2'b01:   lsel = q.lim[1];
					2'b10:   lsel = q.lim[3];
					default: lsel = q.lim[2];
				endcase
			end
			tlfc_pkg::L_ANA:
				lsel = 8'(ana_prod / 18'(tlfc_pkg::ANA_FULL));
			tlfc_pkg::L_OPT1, tlfc_pkg::L_OPT2:
				// A removed board falls back to maximum torque
				lsel = option_present ? option_limit : tlfc_pkg::LIM_MAX;
			default: lsel = tlfc_pkg::LIM_MAX;
		endcase

		// Limit in force, in units where 150 is maximum torque
		if (!vec) begin
			d.lval = tlfc_pkg::LIM_NO;
			d.lon  = 1'b0;
		end else if (len_asg && !len_on) begin
			d.lval = tlfc_pkg::LIM_MAX;
			d.lon  = 1'b1;
		end else begin
			// Mode always enabled when no enable terminal exists
			d.lval = lsel;
			d.lon  = (lsel != tlfc_pkg::LIM_NO);
		end
		// Limiting when demand reaches the limit, same cycle
		d.lflag = d.lon && (torque_demand >= {1'b0, d.lval});
		d.oterm = m_tql & {N_OUT{d.lflag}};

		// Run gate, forcing drop makes the motor coast
		d.restart = 1'b0;
		unique case (q.run)
			tlfc_pkg::RUN_IDLE: begin
				if (run_cmd && run_ok) d.run = tlfc_pkg::RUN_ON;
			end
			tlfc_pkg::RUN_ON: begin
				if (!run_cmd)     d.run = tlfc_pkg::RUN_IDLE;
				else if (!run_ok) d.run = tlfc_pkg::RUN_COAST;
			end
			tlfc_pkg::RUN_COAST: begin
				if (!run_cmd) begin
					d.run = tlfc_pkg::RUN_IDLE;
				end else if (run_ok) begin
					// Restart as the coast restart mode says
					d.run     = tlfc_pkg::RUN_ON;
					d.restart = 1'b1;
				end
			end
			default: d.run = tlfc_pkg::RUN_IDLE;
		endcase

		// Monitors, torque in percent of rated torque
		d.tqv  = vec;
		d.disp = tq;
		d.pmv  = (q.pmon == tlfc_pkg::MON_TQ) ? tq_abs : 16'h0000;
		d.cmv  = (q.cmon == tlfc_pkg::MON_TQ) ? tq_abs : 16'h0000;
		if (q.vmon == tlfc_pkg::MON_TQS)     d.vmv = tq;
		else if (q.vmon == tlfc_pkg::MON_TQ) d.vmv = signed'(tq_abs);
		else                                 d.vmv = 16'sh0000;

		// Read data stand only in the cycle after the strobe
		d.rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				tlfc_pkg::A_METH1: d.rdata = q.meth1;
				tlfc_pkg::A_METH2: d.rdata = q.meth2;
				tlfc_pkg::A_MSET:  d.rdata = {7'h00, q.mset};
				tlfc_pkg::A_LMODE: d.rdata = q.lmode;
				tlfc_pkg::A_PMON:  d.rdata = q.pmon;
				tlfc_pkg::A_VMON:  d.rdata = q.vmon;
				tlfc_pkg::A_CMON:  d.rdata = q.cmon;
				tlfc_pkg::A_RMODE: d.rdata = q.rmode;
				tlfc_pkg::A_POLE1: d.rdata = q.pole1;
				tlfc_pkg::A_POLE2: d.rdata = q.pole2;
				tlfc_pkg::A_STAT:  d.rdata = {1'b0, q.run == tlfc_pkg::RUN_COAST,
				                             q.run == tlfc_pkg::RUN_ON, frc_on & frc_asg,
				                             len_asg, q.tqv, q.lflag, q.lon};
				tlfc_pkg::A_LVAL:  d.rdata = q.lval;
				default: begin
					// Unmapped indexes read as zero
					if (reg_addr[4:2] == 3'b001)       d.rdata = q.lim[reg_addr[1:0]];
					else if (reg_addr[4:3] == 2'b10)  d.rdata = q.ifn[reg_addr[2:0]];
					else if (reg_addr <= tlfc_pkg::A_OFN4)
						d.rdata = q.ofn[3'(reg_addr - tlfc_pkg::A_OFN0)];
				end
			endcase
		end
	end

	// Single register stage for all state
	always_ff @(posedge mclk) begin
		if (rst) begin
			q       <= '0;
			q.meth1 <= tlfc_pkg::R_METH;
			q.meth2 <= tlfc_pkg::R_METH;
			q.lmode <= tlfc_pkg::L_QUAD;
			q.lim   <= {4{tlfc_pkg::LIM_MAX}};
			q.pole1 <= tlfc_pkg::R_POLE;
			q.pole2 <= tlfc_pkg::R_POLE;
			q.ifn   <= {N_IN{tlfc_pkg::F_NONE}};
			q.ofn   <= {N_OUT{tlfc_pkg::F_NONE}};
			q.rmode <= tlfc_pkg::R_ZERO;
			q.run   <= tlfc_pkg::RUN_IDLE;
			q.lval  <= tlfc_pkg::LIM_NO;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata                = q.rdata;
	assign out_term                 = q.oterm;
	assign torque_limit_value       = q.lval;
	assign torque_limit_on          = q.lon;
	assign torque_limited_flag      = q.lflag;
	assign run_enable               = (q.run == tlfc_pkg::RUN_ON);
	assign coast_request            = (q.run == tlfc_pkg::RUN_COAST);
	assign restart_pulse            = q.restart;
	assign restart_after_coast_mode = q.rmode;
	assign flux_forcing_active      = frc_asg & frc_on;
	assign torque_valid             = q.tqv;
	assign torque_display_code      = q.disp;
	assign pulse_monitor_value      = q.pmv;
	assign voltage_monitor_value    = q.vmv;
	assign current_monitor_value    = q.cmv;
	assign pole_count_active        = q.mset ? q.pole2 : q.pole1;

	// ****************************************
	// Assertions
	// ****************************************
	a_limit_needs_vector: assert property (@(posedge mclk) disable iff (rst)
		!vec |=> !torque_limit_on && torque_limit_value == tlfc_pkg::LIM_NO)
		else $error("limit applied outside vector methods");
	a_set2_no_sensor: assert property (@(posedge mclk) disable iff (rst)
		q.meth2 != tlfc_pkg::M_SENSOR)
		else $error("set two holds sensor vector method");
	a_monitor_invalid: assert property (@(posedge mclk) disable iff (rst)
		!vec |=> !torque_valid && torque_display_code == 16'sh0000)
		else $error("torque monitor valid under V/f method");
	a_pulse_torque: assert property (@(posedge mclk) disable iff (rst)
		q.pmon == tlfc_pkg::MON_TQ ##1 q.pmon == tlfc_pkg::MON_TQ
		|-> pulse_monitor_value == $past(tq_abs))
		else $error("pulse monitor lost torque");
	a_forcing_gates_run: assert property (@(posedge mclk) disable iff (rst)
		frc_asg && !frc_on |=> !run_enable)
		else $error("run accepted with forcing off");
	a_coast_on_drop: assert property (@(posedge mclk) disable iff (rst)
		run_enable && run_cmd && !run_ok |=> coast_request && !run_enable)
		else $error("forcing drop did not coast");
	a_switch_select: assert property (@(posedge mclk) disable iff (rst)
		vec && !len_asg && q.lmode == tlfc_pkg::L_TERM && sw1 && !sw2
		|=> torque_limit_value == $past(q.lim[1]))
		else $error("switch one did not pick limit two");
	a_enable_off_max: assert property (@(posedge mclk) disable iff (rst)
		vec && len_asg && !len_on |=> torque_limit_on && torque_limit_value == tlfc_pkg::LIM_MAX)
		else $error("enable off did not force maximum");
	a_flag_needs_limit: assert property (@(posedge mclk) disable iff (rst)
		torque_limited_flag |-> torque_limit_on && {1'b0, torque_limit_value} <= $past(torque_demand))
		else $error("limited flag without active limit");
	a_pole_legal: assert property (@(posedge mclk) disable iff (rst)
		q.pole1 inside {8'h02, 8'h04, 8'h06, 8'h08, 8'h0a}
		&& q.pole2 inside {8'h02, 8'h04, 8'h06, 8'h08, 8'h0a})
		else $error("illegal pole count stored");

endmodule : tlfc_torque_limit

`default_nettype wire

// file: verilog/tlfc_pkg.sv
/*
 * Constants, codes and state types of the torque limit and forcing block.
 * Assumes one 50 MHz control clock and a byte-wide register port.
 */
`default_nettype none

package tlfc_pkg;

	// ****************************************
	// Register indexes on the plain port
	// ****************************************
	localparam logic [4:0] A_METH1  = 5'h00; // Control method, set 1
	localparam logic [4:0] A_METH2  = 5'h01; // Control method, set 2
	localparam logic [4:0] A_MSET   = 5'h02; // Motor set in use
	localparam logic [4:0] A_LMODE  = 5'h03; // Limit mode select
	localparam logic [4:0] A_LIM1   = 5'h04; // Limits 1..4 at 04..07
	localparam logic [4:0] A_PMON   = 5'h08; // Pulse monitor select
	localparam logic [4:0] A_VMON   = 5'h09; // Voltage monitor select
	localparam logic [4:0] A_CMON   = 5'h0a; // Current monitor select
	localparam logic [4:0] A_RMODE  = 5'h0b; // Restart after coast mode
	localparam logic [4:0] A_POLE1  = 5'h0c; // Pole count, set 1
	localparam logic [4:0] A_POLE2  = 5'h0d; // Pole count, set 2
	localparam logic [4:0] A_STAT   = 5'h0e; // Status, read only
	localparam logic [4:0] A_LVAL   = 5'h0f; // Limit in force, read only
	localparam logic [4:0] A_IFN0   = 5'h10; // Input functions 10..17
	localparam logic [4:0] A_OFN0   = 5'h18; // Output functions 18..1c
	localparam logic [4:0] A_OFN4   = 5'h1c; // Last output function

	// ****************************************
	// Codes
	// ****************************************
	localparam logic [7:0] M_SLV    = 8'h03; // Sensorless vector
	localparam logic [7:0] M_SLV0   = 8'h04; // Zero-speed sensorless
	localparam logic [7:0] M_SENSOR = 8'h05; // Vector with sensor
	localparam logic [7:0] L_QUAD   = 8'h00; // Quadrant mode
	localparam logic [7:0] L_TERM   = 8'h01; // Terminal switching
	localparam logic [7:0] L_ANA    = 8'h02; // Analog input
	localparam logic [7:0] L_OPT1   = 8'h03; // Option one
	localparam logic [7:0] L_OPT2   = 8'h04; // Option two
	localparam logic [7:0] F_LEN    = 8'h28; // Limit enable (40)
	localparam logic [7:0] F_SW1    = 8'h29; // Limit switch one (41)
	localparam logic [7:0] F_SW2    = 8'h2a; // Limit switch two (42)
	localparam logic [7:0] F_FORCE  = 8'h37; // Flux forcing (55)
	localparam logic [7:0] F_NONE   = 8'hff; // Terminal unassigned
	localparam logic [7:0] O_TQLIM  = 8'h0a; // Torque limited out (10)
	localparam logic [7:0] MON_TQ   = 8'h02; // Monitor: torque
	localparam logic [7:0] MON_TQS  = 8'h0b; // Voltage monitor: signed
	localparam logic [7:0] LIM_MAX  = 8'h96; // Max torque, 150 %
	localparam logic [7:0] LIM_NO   = 8'hff; // Entry disables limiting
	localparam logic [9:0] ANA_FULL = 10'h3ff; // Code at 10 V

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] R_METH   = 8'h00;
	localparam logic [7:0] R_POLE   = 8'h04;
	localparam logic [7:0] R_ZERO   = 8'h00;

	// Run gating states
	typedef enum logic [2:0] {
		RUN_IDLE  = 3'b001,
		RUN_ON    = 3'b010,
		RUN_COAST = 3'b100
	} tlfc_run_e;

endpackage : tlfc_pkg

`default_nettype wire

// file: tb/tlfc_partner.sv
/*
 * Far-side model: terminal wiring and power stage of the drive.
 * Assumes the bench asks for pin levels and torque demand on mclk edges.
 */
`timescale 1ns/100ps
`default_nettype none

module tlfc_partner (
	input  wire logic        [7:0]  term_req,
	input  wire logic        [8:0]  torque_demand,
	output logic             [7:0]  in_term,
	output logic signed      [15:0] torque_est
);
	// ****************************************
	// Terminal wiring
	// ****************************************
	// Contacts settle 7 ns after the request, off the clock edge
	initial in_term = 8'h00;
	always @(term_req) in_term <= #7 term_req;

	// ****************************************
	// Power stage
	// ****************************************
	// Torque estimate mirrors demand in reverse, so the sign is exercised;
	// overload restriction at low speed is left to the operator
	assign torque_est = -$signed({7'h00, torque_demand});
endmodule : tlfc_partner

`default_nettype wire

// file: tb/tb.sv
/*
 * Self-checking bench of the torque limit and forcing block.
 * Assumes the design package is compiled first and the partner model beside it.
 */
`timescale 1ns/100ps
`default_nettype none

module tb;
	// ****************************************
	// Signals
	// ****************************************
	logic               mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic               run_cmd = 1'b0, motor_reverse = 1'b0, motor_regen = 1'b0;
	logic        [4:0]  reg_addr = 5'h00;
	logic        [7:0]  reg_wdata = 8'h00, term_req = 8'h00, reg_rdata, in_term;
	logic        [8:0]  torque_demand = 9'h000;
	logic        [9:0]  auxiliary_analog_input = 10'h000;
	logic        [4:0]  out_term;
	logic        [7:0]  torque_limit_value;
	logic signed [15:0] torque_est, torque_display_code, voltage_monitor_value;
	logic        [15:0] pulse_monitor_value, current_monitor_value;
	logic        [7:0]  restart_after_coast_mode, pole_count_active, option_limit = 8'h00;
	logic               flux_forcing_active, option_present = 1'b0;
	logic               torque_limit_on, torque_limited_flag, run_enable, coast_request;
	logic               restart_pulse, torque_valid, seen_pulse;
	int                 failures = 0, comparisons = 0; // Mismatch and check counts
	logic        [7:0]  q_exp [4] = '{8'h0a, 8'h28, 8'h1e, 8'h14}; // By {rev,regen}
	logic        [7:0]  t_exp [4] = '{8'h0a, 8'h14, 8'h28, 8'h1e}; // By {sw2,sw1}
	logic        [9:0]  a_in  [3] = '{10'h3ff, 10'h200, 10'h000};
	logic        [7:0]  a_exp [3] = '{8'h96, 8'h4b, 8'h00}; // Floor of code*150/1023

	always #10 mclk = ~mclk;

	tlfc_torque_limit tlfc_torque_limit_inst (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .in_term, .out_term, .run_cmd, .motor_reverse, .motor_regen,
		.torque_demand, .torque_est, .auxiliary_analog_input, .option_present,
		.option_limit, .torque_limit_value, .torque_limit_on, .torque_limited_flag,
		.run_enable, .coast_request, .restart_pulse, .restart_after_coast_mode,
		.flux_forcing_active, .torque_valid, .torque_display_code, .pulse_monitor_value,
		.voltage_monitor_value, .current_monitor_value, .pole_count_active);
	tlfc_partner tlfc_partner_inst (.term_req, .torque_demand, .in_term, .torque_est);

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One-cycle write strobe
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, e});
	endtask : rd
	// Pins need three sync edges, one to agree and one for the outputs
	task automatic settle;
		repeat (6) @(posedge mclk);
		#1;
	endtask : settle
	task automatic pin(input int i, input logic v);
		@(posedge mclk);
		term_req[i] <= v;
		settle;
	endtask : pin
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done

	// ****************************************
	// Watchdog, far beyond the roughly 210 cycles needed
	// ****************************************
	initial begin
		repeat (3000) @(posedge mclk);
		failures++;
		test_done;
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		rd(tlfc_pkg::A_LIM1, 8'h96);
		chk("limit", {8'h00, torque_limit_value}, 16'h00ff);
		wr(tlfc_pkg::A_POLE1, 8'h03);
		rd(tlfc_pkg::A_POLE1, 8'h04);
		wr(tlfc_pkg::A_METH2, tlfc_pkg::M_SENSOR);
		rd(tlfc_pkg::A_METH2, 8'h00);
		wr(tlfc_pkg::A_LIM1, 8'h97);
		rd(tlfc_pkg::A_LIM1, 8'h96);
		wr(tlfc_pkg::A_LMODE, tlfc_pkg::L_OPT1);
		rd(tlfc_pkg::A_LMODE, 8'h00);
		rd(5'h1d, 8'h00);
		wr(tlfc_pkg::A_METH1, tlfc_pkg::M_SLV);
		for (int i = 0; i < 4; i++) wr(tlfc_pkg::A_LIM1 + 5'(i), 8'(10 * (i + 1)));
		// Quadrants walked through every {reverse,regen} pair
		for (int q = 0; q < 4; q++) begin
			@(posedge mclk);
			{motor_reverse, motor_regen} <= 2'(q);
			settle;
			chk("quadrant", {8'h00, torque_limit_value}, {8'h00, q_exp[q]});
			chk("limit_on", {15'h0, torque_limit_on}, 16'h0001);
		end
		wr(tlfc_pkg::A_IFN0, tlfc_pkg::F_SW1);
		wr(tlfc_pkg::A_IFN0 + 5'h01, tlfc_pkg::F_SW2);
		wr(tlfc_pkg::A_LMODE, tlfc_pkg::L_TERM);
		for (int t = 0; t < 4; t++) begin
			@(posedge mclk);
			term_req[1:0] <= 2'(t);
			settle;
			chk("switched", {8'h00, torque_limit_value}, {8'h00, t_exp[t]});
		end
		wr(tlfc_pkg::A_LMODE, tlfc_pkg::L_ANA);
		for (int k = 0; k < 3; k++) begin
			@(posedge mclk);
			auxiliary_analog_input <= a_in[k];
			settle;
			chk("analog", {8'h00, torque_limit_value}, {8'h00, a_exp[k]});
		end
		// Enable assigned but off: maximum torque applies
		wr(tlfc_pkg::A_IFN0 + 5'h02, tlfc_pkg::F_LEN);
		wr(tlfc_pkg::A_OFN0, tlfc_pkg::O_TQLIM);
		torque_demand <= 9'h096;
		settle;
		chk("enable_off", {8'h00, torque_limit_value}, 16'h0096);
		chk("flag", {15'h0, torque_limited_flag}, 16'h0001);
		chk("out_term", {15'h0, out_term[0]}, 16'h0001);
		@(posedge mclk);
		auxiliary_analog_input <= 10'h200;
		torque_demand <= 9'h040;
		pin(2, 1'b1);
		chk("enable_on", {8'h00, torque_limit_value}, 16'h004b);
		rd(tlfc_pkg::A_LVAL, 8'h4b);
		chk("out_term", {15'h0, out_term[0]}, 16'h0000);
		wr(tlfc_pkg::A_PMON, tlfc_pkg::MON_TQ);
		wr(tlfc_pkg::A_VMON, tlfc_pkg::MON_TQS);
		wr(tlfc_pkg::A_CMON, tlfc_pkg::MON_TQ);
		settle;
		chk("pulse_mon", pulse_monitor_value, 16'h0040);
		chk("volt_mon", voltage_monitor_value, 16'hffc0);
		chk("cur_mon", current_monitor_value, 16'h0040);
		chk("display", torque_display_code, 16'hffc0);
		// Forcing gates runs, drop coasts, return restarts
		wr(tlfc_pkg::A_IFN0 + 5'h03, tlfc_pkg::F_FORCE);
		run_cmd <= 1'b1;
		settle;
		chk("run_gated", {15'h0, run_enable}, 16'h0000);
		pin(3, 1'b1);
		chk("run_on", {15'h0, run_enable}, 16'h0001);
		chk("forcing", {15'h0, flux_forcing_active}, 16'h0001);
		rd(tlfc_pkg::A_STAT, 8'h3d);
		pin(3, 1'b0);
		chk("coast", {15'h0, coast_request}, 16'h0001);
		chk("forcing_off", {15'h0, flux_forcing_active}, 16'h0000);
		wr(tlfc_pkg::A_RMODE, 8'h02);
		#1 chk("rmode", {8'h00, restart_after_coast_mode}, 16'h0002);
		seen_pulse = 1'b0;
		@(posedge mclk);
		term_req[3] <= 1'b1;
		repeat (10) begin
			@(posedge mclk);
			#1 if (restart_pulse === 1'b1) seen_pulse = 1'b1;
		end
		chk("restart", {15'h0, seen_pulse}, 16'h0001);
		// Fitted option board supplies the limit
		@(posedge mclk);
		option_present <= 1'b1;
		option_limit <= 8'h33;
		wr(tlfc_pkg::A_LMODE, tlfc_pkg::L_OPT1);
		wr(tlfc_pkg::A_VMON, tlfc_pkg::MON_TQ);
		settle;
		chk("option", {8'h00, torque_limit_value}, 16'h0033);
		chk("volt_mag", voltage_monitor_value, 16'h0040);
		wr(tlfc_pkg::A_METH1, 8'h00);
		settle;
		chk("vf_limit", {8'h00, torque_limit_value}, 16'h00ff);
		chk("vf_valid", {15'h0, torque_valid}, 16'h0000);
		chk("poles1", {8'h00, pole_count_active}, 16'h0004);
		wr(tlfc_pkg::A_POLE2, 8'h08);
		wr(tlfc_pkg::A_MSET, 8'h01);
		#1 chk("poles2", {8'h00, pole_count_active}, 16'h0008);
		test_done;
	end
endmodule : tb

`default_nettype wire
